// [rtl/crcb_top.sv]
// Contract
// R01: Checksum lives in a 16-bit register using polynomial x^16+x^12+x^5+1.
// R02: High-register write loads bits 15-8 and arms the seed sequence.
// R03: Armed low-register write loads bits 7-0, disarms, no shifting.
// R04: Unarmed low-register write shifts its eight bits in, MSB first.
// R05: A data byte is fully absorbed by the following bus cycle.
// R06: High-register read returns bits 15-8, no side effects.
// R07: Low-register read returns bits 7-0, no side effects.
// R08: Result is raw register contents, never complemented, no augmentation.
// R09: High-register write restarts the seed sequence whatever is in progress.
// R10: Zero and all-ones seeds give the published reference checksums.
// R11: Block keeps fully working while the processor waits.
// R12: Deep stop modes halt the block and return it to reset.
// R13: Light stop freezes the calculation; it resumes on return to run.
// R14: Host writes seed high, seed low, then data; reads a cycle later.
// R15: After reset the seed sequence is disarmed.
// R16: Per bit: feedback is input XOR bit 15, shift left, taps 12, 5, 0.
//
// Design decisions made here: the address map and the APB slave port.

// ==========================================
// Command queue
module crcb_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [PTR_W:0] DEPTH_CNT = DEPTH[PTR_W:0];

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wptr;
    logic [PTR_W-1:0] rptr;
    logic [PTR_W:0] count;

    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    // Flush stalls the writer rather than dropping its word
    assign in_ready = (count != DEPTH_CNT) && !flush;
    assign out_valid = (count != '0) && !flush;
    assign out_data = mem[rptr];

    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        ptr_inc = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
    endfunction

    always_ff @(posedge pclk) begin
        if (push) begin
            mem[wptr] <= in_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
        end else if (flush) begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wptr <= ptr_inc(wptr);
            end
            if (pop) begin
                rptr <= ptr_inc(rptr);
            end
            count <= count + {{PTR_W{1'b0}}, push} - {{PTR_W{1'b0}}, pop};
        end
    end
endmodule

// ==========================================
// Generator with APB access
module crcb_top #(
    parameter int FIFO_DEPTH = crcb_pkg::FIFO_DEPTH
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [crcb_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic stop_light,
    input wire logic stop_deep
);
    import crcb_pkg::*;

    logic [CRC_W-1:0] crc;
    logic armed;
    logic rd_ok;
    logic [CRC_W-1:0] next_crc;
    logic next_armed;

    // ==========================================
    // One byte per cycle, MSB first
    function automatic logic [CRC_W-1:0] crc_byte(
        input logic [CRC_W-1:0] c,
        input logic [BYTE_W-1:0] d
    );
        logic [CRC_W-1:0] r;
        logic fb;
        r = c;
        for (int i = BYTE_W - 1; i >= 0; i--) begin
            fb = d[i] ^ r[CRC_W-1]; // R16
            r = {r[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : '0); // R01
        end
        crc_byte = r; // R08 R10
    endfunction

    // ==========================================
    // Bus decode
    wire sel_high = (paddr == ADDR_RESULT_HIGH);
    wire sel_low = (paddr == ADDR_RESULT_LOW);
    wire mapped = sel_high || sel_low;
    wire access = psel && penable;
    wire wr_req = access && pwrite && mapped;
    wire [CRC_W-1:0] rd_word = sel_high ? {8'h00, crc[CRC_W-1:HIGH_LSB]} : (sel_low ? {8'h00, crc[BYTE_W-1:0]} : '0);

    wire q_in_ready;
    wire q_out_valid;
    wire [ITEM_W-1:0] q_out_data;
    wire eng_ready = !stop_light && !stop_deep; // R13
    wire eng_take = q_out_valid && eng_ready; // R11
    wire [ITEM_W-1:0] q_in_data = {sel_low ? KIND_LOW : KIND_HIGH, pwdata[BYTE_W-1:0]};
    wire item_low = (q_out_data[KIND_POS] == KIND_LOW);
    wire [BYTE_W-1:0] item_byte = q_out_data[BYTE_W-1:0];

    // Reads wait until all queued bytes have been absorbed
    assign pready = !mapped || (pwrite ? q_in_ready : rd_ok); // R14
    assign pslverr = access && !mapped;

    crcb_fifo #(
        .WIDTH(ITEM_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .flush(stop_deep),
        .in_valid(wr_req),
        .in_ready(q_in_ready),
        .in_data(q_in_data),
        .out_valid(q_out_valid),
        .out_ready(eng_ready),
        .out_data(q_out_data)
    );

    // ==========================================
    // Engine
    always_comb begin
        next_crc = crc;
        next_armed = armed;
        if (stop_deep) begin
            next_crc = CRC_RESET; // R12
            next_armed = 1'b0;
        end else if (eng_take) begin
            if (!item_low) begin
                next_crc = {item_byte, crc[BYTE_W-1:0]}; // R02 R09
                next_armed = 1'b1;
            end else if (armed) begin
                next_crc = {crc[CRC_W-1:HIGH_LSB], item_byte}; // R03
                next_armed = 1'b0;
            end else begin
                next_crc = crc_byte(crc, item_byte); // R04 R05
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crc <= CRC_RESET;
            armed <= 1'b0; // R15
        end else begin
            crc <= next_crc;
            armed <= next_armed;
        end
    end

    // Read data sampled a cycle ahead; crc cannot move while the queue stays empty and deep stop is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            rd_ok <= 1'b0;
        end else begin
            prdata <= {16'h0000, rd_word}; // R06 R07 R08
            rd_ok <= !q_out_valid && !stop_deep;
        end
    end

    // ==========================================
    // Assertions
    wire rd_done = access && !pwrite && pready;

    seed_high_a: assert property (@(posedge pclk) disable iff (!presetn) // R02
        eng_take && !stop_deep && !item_low |=> crc[CRC_W-1:HIGH_LSB] == $past(item_byte) && armed)
        else $error("high seed byte not loaded");

    seed_restart_a: assert property (@(posedge pclk) disable iff (!presetn) // R09
        armed && eng_take && !item_low && !stop_deep |=> armed && $stable(crc[BYTE_W-1:0]))
        else $error("seed restart failed");

    seed_low_a: assert property (@(posedge pclk) disable iff (!presetn) // R03
        eng_take && !stop_deep && item_low && armed
        |=> crc == {$past(crc[CRC_W-1:HIGH_LSB]), $past(item_byte)} && !armed)
        else $error("low seed byte not loaded");

    data_shift_a: assert property (@(posedge pclk) disable iff (!presetn) // R04
        eng_take && !stop_deep && item_low && !armed |=> crc == crc_byte($past(crc), $past(item_byte)))
        else $error("data byte shifted wrongly");

    ref_vector_a: assert property (@(posedge pclk) disable iff (!presetn) // R10
        crc_byte(16'h0000, 8'h41) == 16'h58e5 && crc_byte(16'hffff, 8'h41) == 16'hb915)
        else $error("reference checksum mismatch");

    drain_a: assert property (@(posedge pclk) disable iff (!presetn) // R05
        wr_req && q_in_ready && !q_out_valid && eng_ready ##1 eng_ready |=> !q_out_valid)
        else $error("byte not absorbed next cycle");

    read_high_a: assert property (@(posedge pclk) disable iff (!presetn) // R06
        rd_done && sel_high |-> prdata == {24'h00_0000, crc[CRC_W-1:HIGH_LSB]})
        else $error("high read mismatch");

    read_low_a: assert property (@(posedge pclk) disable iff (!presetn) // R07
        rd_done && sel_low |-> prdata == {24'h00_0000, crc[BYTE_W-1:0]} ##1 $stable(armed))
        else $error("low read mismatch");

    freeze_a: assert property (@(posedge pclk) disable iff (!presetn) // R13
        stop_light && !stop_deep |=> $stable(crc) && $stable(armed))
        else $error("calculation moved in light stop");

    deep_reset_a: assert property (@(posedge pclk) disable iff (!presetn) // R12
        stop_deep |=> crc == CRC_RESET && !armed && !q_out_valid)
        else $error("deep stop did not reset");

    reset_disarm_a: assert property (@(posedge pclk) disable iff (!presetn) // R15
        $rose(presetn) |-> !armed && crc == CRC_RESET)
        else $error("armed after reset");

    // ==========================================
    // Bus protocol checks
    bus_ok_a: assert property (@(posedge pclk) disable iff (!presetn) // R14
        access && mapped |-> !pslverr)
        else $error("error flagged on a mapped access");

    bus_err_a: assert property (@(posedge pclk) disable iff (!presetn) // R14
        access && !mapped |-> pready && pslverr)
        else $error("unmapped access not refused");

    err_idle_a: assert property (@(posedge pclk) disable iff (!presetn) // R14
        !access |-> !pslverr)
        else $error("error flagged outside an access");

    rd_upper_a: assert property (@(posedge pclk) disable iff (!presetn) // R06
        rd_done |-> prdata[31:BYTE_W] == '0)
        else $error("read data upper bits not zero");

    // A read answered early would show a checksum still moving
    read_wait_a: assert property (@(posedge pclk) disable iff (!presetn) // R05
        rd_done && mapped |-> !$past(q_out_valid))
        else $error("read answered while bytes were queued");

    wr_accept_a: assert property (@(posedge pclk) disable iff (!presetn) // R05
        access && pwrite && mapped && !stop_deep && !q_out_valid |-> pready)
        else $error("write refused with empty queue");

    read_quiet_a: assert property (@(posedge pclk) disable iff (!presetn) // R07
        access && !pwrite && !q_out_valid && !stop_deep |=> $stable(crc) && $stable(armed))
        else $error("read disturbed the generator");

    deep_stall_a: assert property (@(posedge pclk) disable iff (!presetn) // R12
        stop_deep && access && pwrite && mapped |-> !pready)
        else $error("write taken in deep stop");

    light_accept_a: assert property (@(posedge pclk) disable iff (!presetn) // R13
        stop_light && !stop_deep && access && pwrite && mapped && !q_out_valid |-> pready)
        else $error("write refused in light stop");

    reset_read_a: assert property (@(posedge pclk) disable iff (!presetn) // R15
        $rose(presetn) |-> prdata == '0 && !q_out_valid)
        else $error("read data or queue not clear after reset");

    // ==========================================
    // Generator and queue checks
    low_disarm_a: assert property (@(posedge pclk) disable iff (!presetn) // R03
        eng_take && item_low |=> !armed)
        else $error("armed after a low byte");

    seed_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // R02
        eng_take && !item_low |=> $stable(crc[BYTE_W-1:0]))
        else $error("high seed byte disturbed low bits");

    restart_any_a: assert property (@(posedge pclk) disable iff (!presetn) // R09
        eng_take && !item_low && !armed |=> armed)
        else $error("high write did not restart seeding");

    // Hand-worked cases: a set input bit and a set bit 15 feed back alike
    tap_step_a: assert property (@(posedge pclk) disable iff (!presetn) // R16
        crc_byte(16'h8000, 8'h00) == 16'h9188 && crc_byte(16'h0000, 8'h80) == 16'h9188)
        else $error("feedback taps wrong");

    result_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R05
        eng_take && item_low && !armed ##1 !q_out_valid && !stop_deep |=> $stable(crc))
        else $error("result moved after absorption");

    queue_pass_a: assert property (@(posedge pclk) disable iff (!presetn) // R04
        wr_req && q_in_ready && !q_out_valid && !stop_deep
        |=> q_out_data == $past(q_in_data) && (q_out_valid || stop_deep))
        else $error("queued byte lost or reordered");

    freeze_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R13
        stop_light && !stop_deep && q_out_valid |=> q_out_valid || stop_deep)
        else $error("queue drained in light stop");

    full_flag_a: assert property (@(posedge pclk) disable iff (!presetn) // R14
        wr_req && !stop_deep && !pready |-> q_out_valid)
        else $error("write stalled with queue empty");

    seed_cover: cover property (@(posedge pclk) disable iff (!presetn)
        eng_take && !item_low ##[1:8] eng_take && item_low && armed);

    data_cover: cover property (@(posedge pclk) disable iff (!presetn)
        eng_take && item_low && !armed ##2 rd_done);

    full_cover: cover property (@(posedge pclk) disable iff (!presetn)
        wr_req && !q_in_ready);

    freeze_cover: cover property (@(posedge pclk) disable iff (!presetn)
        stop_light && q_out_valid ##1 !stop_light);

    bus_err_cover: cover property (@(posedge pclk) disable iff (!presetn)
        access && !mapped && pwrite);

endmodule

// [rtl/crcb_pkg.sv]
package crcb_pkg;

    // ==========================================
    // Register map
    localparam logic [11:0] ADDR_RESULT_HIGH = 12'h000;
    localparam logic [11:0] ADDR_RESULT_LOW = 12'h004;
    localparam int ADDR_W = 12;

    // ==========================================
    // Generator
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_RESET = 16'h0000;
    localparam int CRC_W = 16;
    localparam int BYTE_W = 8;
    localparam int HIGH_LSB = 8;

    // ==========================================
    // Command queue
    localparam int FIFO_DEPTH = 8;
    localparam int ITEM_W = 9;
    localparam int KIND_POS = 8;

    typedef enum logic [0:0] {
        KIND_HIGH = 1'b0,
        KIND_LOW = 1'b1
    } crcb_kind_t;

endpackage

// [bench/crcb_cpu.sv]
// ==========================================
// Host model: one APB transfer at a time
module crcb_cpu (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [crcb_pkg::ADDR_W-1:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 100ps;
    import crcb_pkg::*;
    int nwr = 0;
    initial begin
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = '0;
        pwdata = '0;
    end
    // Entered just after a rising edge; returns just after one
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Result reads wait for the answer, never a fixed count
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        nwr += int'(w);
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines must not keep showing the last value
        paddr <= ~a;
        pwdata <= ~d;
        @(posedge pclk);
    endtask
endmodule

// [bench/tb_crc16_byte_generator.sv]
module tb_crc16_byte_generator;
    timeunit 1ns;
    timeprecision 100ps;
    import crcb_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, stop_light, stop_deep;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    int miscompares = 0;
    int checked = 0;
    int cyc = 0;
    crcb_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .stop_light(stop_light), .stop_deep(stop_deep));
    crcb_cpu cpu (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // ==========================================
    // Helpers
    initial begin
        pclk = 0;
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            finish_test();
        end
    end
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic e;
        cpu.xfer(1'b1, a, 32'(d), q, e);
    endtask
    task automatic rd(output logic [15:0] v);
        logic [31:0] q;
        logic e;
        cpu.xfer(1'b0, ADDR_RESULT_HIGH, 32'h0000_0000, q, e);
        v[15:8] = q[7:0];
        chk(16'(e), 16'h0000);
        cpu.xfer(1'b0, ADDR_RESULT_LOW, 32'h0000_0000, q, e);
        v[7:0] = q[7:0];
        chk(16'(e), 16'h0000);
    endtask
    task automatic seed(input logic [15:0] s);
        wr(ADDR_RESULT_HIGH, s[15:8]);
        wr(ADDR_RESULT_LOW, s[7:0]);
    endtask
    task automatic feed(input string s);
        for (int i = 0; i < s.len(); i++) wr(ADDR_RESULT_LOW, s[i]);
    endtask
    task automatic finish_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ==========================================
    // Scenarios
    task automatic t_ref();
        logic [15:0] v;
        logic [15:0] sd[4] = '{16'h0000, 16'hffff, 16'h0000, 16'hffff};
        logic [15:0] ex[4] = '{16'h58e5, 16'hb915, 16'h31c3, 16'h29b1};
        string ms[4] = '{"A", "A", "123456789", "123456789"};
        rd(v);
        chk(v, 16'h0000);
        feed("A");
        rd(v);
        chk(v, 16'h58e5);
        seed(16'h1234);
        rd(v);
        chk(v, 16'h1234);
        for (int i = 0; i < 4; i++) begin
            seed(sd[i]);
            feed(ms[i]);
            rd(v);
            chk(v, ex[i]);
            rd(v);
            chk(v, ex[i]);
        end
        $display("reference done");
    endtask
    task automatic t_restart();
        logic [15:0] v;
        seed(16'h0000);
        feed("12");
        seed(16'hffff);
        feed("A");
        rd(v);
        chk(v, 16'hb915);
        $display("restart done");
    endtask
    task automatic t_stops();
        logic [15:0] v;
        int n0;
        wr(ADDR_RESULT_HIGH, 8'hff);
        stop_deep <= 1'b1;
        repeat (3) @(posedge pclk);
        stop_deep <= 1'b0;
        @(posedge pclk);
        rd(v);
        chk(v, 16'h0000);
        feed("A");
        rd(v);
        chk(v, 16'h58e5);
        seed(16'h0000);
        stop_light <= 1'b1;
        n0 = cpu.nwr;
        // Frozen engine: eight bytes fill the queue, the ninth waits
        fork
            feed("123456789");
        join_none
        repeat (30) @(posedge pclk);
        chk(16'(cpu.nwr - n0), 16'(FIFO_DEPTH));
        chk(16'(pready), 16'h0000);
        stop_light <= 1'b0;
        wait fork;
        rd(v);
        chk(v, 16'h31c3);
        $display("stops done");
    endtask
    task automatic t_unmapped();
        logic [31:0] q;
        logic e;
        logic [15:0] v;
        cpu.xfer(1'b1, 12'h008, 32'h0000_00aa, q, e);
        chk(16'(e), 16'h0001);
        cpu.xfer(1'b0, 12'h008, 32'h0000_0000, q, e);
        chk(q[15:0], 16'h0000);
        rd(v);
        chk(v, 16'h31c3);
        $display("unmapped done");
    endtask
    initial begin
        presetn = 1'b0;
        stop_light = 1'b0;
        stop_deep = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_ref();
        t_restart();
        t_stops();
        t_unmapped();
        finish_test();
    end
endmodule
